// *** hdl/ued_block.sv ***
// Endpoint descriptor RAM with the buffer manager's lookup and completion logic.
// Assumes the microcontroller bus and the buffer manager run on this same clock.
`timescale 1ns/100ps
`default_nettype none

module ued_block (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [15:0] mcu_addr,
  input wire logic mcu_wr,
  input wire logic mcu_rd,
  input wire logic [7:0] mcu_wdata,
  output logic [7:0] mcu_rdata,
  output logic mcu_rvalid,
  input wire logic bm_req,
  input wire ued_pkg::ued_ep_sel_t bm_sel,
  output logic bm_ans_valid,
  output ued_pkg::ued_bm_ans_t bm_ans,
  input wire logic bm_done,
  input wire ued_pkg::ued_ep_sel_t bm_done_sel,
  input wire logic [6:0] bm_done_count,
  input wire logic bm_mem_wr,
  input wire logic bm_mem_rd,
  input wire logic [10:0] bm_mem_addr,
  input wire logic [7:0] bm_mem_wdata,
  output logic [7:0] bm_mem_rdata,
  output logic transaction_irq
);

  // Address inside the descriptor RAM
  function automatic logic [8:0] ram_index(input logic [15:0] addr);
    logic [15:0] d;
    d = addr - ued_pkg::RAM_BASE;
    return d[8:0];
  endfunction : ram_index

  // Address falls into the RAM window at all
  function automatic logic in_ram(input logic [15:0] addr);
    return (addr >= ued_pkg::RAM_BASE) && (addr <= ued_pkg::RAM_LAST);
  endfunction : in_ram

  // Holes after the out and in descriptor groups
  function automatic logic is_reserved(input logic [15:0] addr);
    logic r;
    r = (addr >= ued_pkg::OUT_RSVD_FIRST) && (addr <= ued_pkg::OUT_RSVD_LAST);
    r = r | ((addr >= ued_pkg::IN_RSVD_FIRST) && (addr <= ued_pkg::IN_RSVD_LAST));
    return r;
  endfunction : is_reserved

  // Address lies inside one of the six descriptors
  function automatic logic is_desc(input logic [15:0] addr);
    logic o;
    logic i;
    o = (addr >= ued_pkg::OUT_DESC_BASE) && (addr < ued_pkg::OUT_RSVD_FIRST);
    i = (addr >= ued_pkg::IN_DESC_BASE) && (addr < ued_pkg::IN_RSVD_FIRST);
    return o | i;
  endfunction : is_desc

  // Slot number of a descriptor address
  function automatic logic [2:0] slot_of_addr(input logic [15:0] addr);
    logic [15:0] d;
    logic [2:0] s;
    if (addr >= ued_pkg::IN_DESC_BASE)
    begin
      d = addr - ued_pkg::IN_DESC_BASE;
      s = {1'b0, d[4:3]} + ued_pkg::IN_SLOT_OFFSET;
    end
    else
    begin
      d = addr - ued_pkg::OUT_DESC_BASE;
      s = {1'b0, d[4:3]};
    end
    return s;
  endfunction : slot_of_addr

  // Slot number of an endpoint; endpoint 0 has no RAM descriptor
  function automatic logic [2:0] slot_of_ep(input ued_pkg::ued_ep_sel_t sel);
    logic [2:0] s;
    s = {1'b0, sel.ep} - 3'h1;
    if (sel.dir_in)
    begin
      s = s + ued_pkg::IN_SLOT_OFFSET;
    end
    if (sel.ep == 2'h0)
    begin
      s = 3'h0;
    end
    return s;
  endfunction : slot_of_ep

  // RAM index of one entry of a descriptor
  function automatic logic [8:0] entry_index(input logic [2:0] slot, input logic [2:0] ofs);
    logic [15:0] b;
    if (slot >= ued_pkg::IN_SLOT_OFFSET)
    begin
      b = ued_pkg::IN_DESC_BASE + {10'h000, slot - ued_pkg::IN_SLOT_OFFSET, 3'h0};
    end
    else
    begin
      b = ued_pkg::OUT_DESC_BASE + {10'h000, slot, 3'h0};
    end
    b = b + {13'h0000, ofs};
    return ram_index(b);
  endfunction : entry_index

  // Buffer and descriptor bytes; only the configuration bytes need a reset value
  logic [7:0] ram [0:ued_pkg::RAM_BYTES-1];
  logic [7:0] cfg [0:ued_pkg::SLOT_COUNT-1];

  logic [8:0] mcu_idx;
  logic mcu_hit;
  logic mcu_desc;
  logic [2:0] mcu_slot;
  logic [2:0] mcu_ofs;
  logic mcu_spare;
  logic mcu_cfg_sel;
  logic mcu_ram_wr;
  logic [7:0] mcu_wval;
  logic [7:0] next_mcu_rdata;

  // Microcontroller access decode
  always_comb
  begin
    mcu_idx = ram_index(mcu_addr);
    mcu_hit = in_ram(mcu_addr) && !is_reserved(mcu_addr);
    mcu_desc = is_desc(mcu_addr);
    mcu_slot = slot_of_addr(mcu_addr);
    mcu_ofs = mcu_addr[2:0];
    mcu_spare = mcu_desc && ((mcu_ofs == ued_pkg::OFS_SPARE_A) || (mcu_ofs == ued_pkg::OFS_SPARE_B));
    mcu_cfg_sel = mcu_hit && mcu_desc && (mcu_ofs == ued_pkg::OFS_CONFIGURATION);
    mcu_ram_wr = mcu_wr && mcu_hit && !mcu_spare && !mcu_cfg_sel;
    // Reserved top bit of the size entry cannot be written
    if (mcu_desc && (mcu_ofs == ued_pkg::OFS_BUFFER_SIZE))
    begin
      mcu_wval = mcu_wdata & ued_pkg::SIZE_WRITE_MASK;
    end
    else
    begin
      mcu_wval = mcu_wdata;
    end
    if (!mcu_hit || mcu_spare)
    begin
      next_mcu_rdata = 8'h00;
    end
    else if (mcu_cfg_sel)
    begin
      next_mcu_rdata = cfg[mcu_slot] & ued_pkg::CFG_WRITE_MASK;
    end
    else
    begin
      next_mcu_rdata = ram[mcu_idx];
    end
  end

  logic [15:0] bm_xaddr;
  logic [8:0] bm_idx;
  logic bm_mem_ok;
  logic [7:0] next_bm_mem_rdata;

  // Buffer manager data port: an 11-bit address covers the 2 KB window
  always_comb
  begin
    bm_xaddr = ued_pkg::BUF_WINDOW_BASE | {5'h00, bm_mem_addr};
    bm_idx = ram_index(bm_xaddr);
    // Packet buffers, endpoint 0 buffers and setup block; never descriptors
    bm_mem_ok = (bm_xaddr >= ued_pkg::RAM_BASE) && (bm_xaddr < ued_pkg::OUT_DESC_BASE);
    if (bm_mem_ok)
    begin
      next_bm_mem_rdata = ram[bm_idx];
    end
    else
    begin
      next_bm_mem_rdata = 8'h00;
    end
  end

  logic [2:0] q_slot;
  logic [7:0] q_cfg;
  logic q_use_y;
  logic [7:0] q_base;
  logic [7:0] q_count;
  logic [7:0] q_size;
  ued_pkg::ued_bm_ans_t next_ans;

  // Lookup for the buffer manager at the start of a transaction
  always_comb
  begin
    q_slot = slot_of_ep(bm_sel);
    q_cfg = cfg[q_slot];
    // Y entries are only looked at with double buffering on
    q_use_y = q_cfg[ued_pkg::CFG_DOUBLE_BUF_BIT] && q_cfg[ued_pkg::CFG_TOGGLE_BIT];
    q_base = q_use_y ? ram[entry_index(q_slot, ued_pkg::OFS_Y_BASE)]
                     : ram[entry_index(q_slot, ued_pkg::OFS_X_BASE)];
    q_count = q_use_y ? ram[entry_index(q_slot, ued_pkg::OFS_Y_COUNT)]
                      : ram[entry_index(q_slot, ued_pkg::OFS_X_COUNT)];
    q_size = ram[entry_index(q_slot, ued_pkg::OFS_BUFFER_SIZE)];
    next_ans.use_y = q_use_y;
    next_ans.toggle = q_cfg[ued_pkg::CFG_TOGGLE_BIT];
    next_ans.start_addr = {q_base, ued_pkg::BASE_PAD};
    next_ans.count = q_count[6:0];
    next_ans.size = q_size[6:0];
    if ((bm_sel.ep == 2'h0) || !q_cfg[ued_pkg::CFG_UBM_USE_BIT])
    begin
      next_ans.resp = ued_pkg::UED_RESP_IGNORE;
    end
    else if (q_cfg[ued_pkg::CFG_STALL_BIT])
    begin
      next_ans.resp = ued_pkg::UED_RESP_STALL;
    end
    else if (q_count[ued_pkg::COUNT_FULL_BIT])
    begin
      next_ans.resp = ued_pkg::UED_RESP_NAK;
    end
    else
    begin
      next_ans.resp = ued_pkg::UED_RESP_READY;
    end
  end

  logic d_valid;
  logic [2:0] d_slot;
  logic [7:0] d_cfg;
  logic [8:0] d_cnt_idx;
  logic [7:0] d_cnt_new;

  // Completion: mark the used buffer full; OUT also stores the received count
  always_comb
  begin
    d_slot = slot_of_ep(bm_done_sel);
    d_cfg = cfg[d_slot];
    d_valid = bm_done && (bm_done_sel.ep != 2'h0) && d_cfg[ued_pkg::CFG_UBM_USE_BIT];
    if (d_cfg[ued_pkg::CFG_DOUBLE_BUF_BIT] && d_cfg[ued_pkg::CFG_TOGGLE_BIT])
    begin
      d_cnt_idx = entry_index(d_slot, ued_pkg::OFS_Y_COUNT);
    end
    else
    begin
      d_cnt_idx = entry_index(d_slot, ued_pkg::OFS_X_COUNT);
    end
    // IN keeps the firmware count, OUT records what the host sent
    if (bm_done_sel.dir_in)
    begin
      d_cnt_new = ram[d_cnt_idx] | ued_pkg::COUNT_FULL_MASK;
    end
    else
    begin
      d_cnt_new = {1'b1, bm_done_count};
    end
  end

  // RAM writes; completion is last so it wins over a firmware write to the same count
  always_ff @(posedge clock)
  begin
    if (mcu_ram_wr)
    begin
      ram[mcu_idx] <= mcu_wval;
    end
    if (bm_mem_wr && bm_mem_ok)
    begin
      ram[bm_idx] <= bm_mem_wdata;
    end
    if (d_valid)
    begin
      ram[d_cnt_idx] <= d_cnt_new;
    end
  end

  // Configuration bytes; the hardware toggle flip wins over a same-cycle write
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < ued_pkg::SLOT_COUNT; i++)
      begin
        cfg[i] <= ued_pkg::CFG_RESET;
      end
    end
    else
    begin
      if (mcu_wr && mcu_cfg_sel)
      begin
        cfg[mcu_slot] <= mcu_wdata & ued_pkg::CFG_WRITE_MASK;
      end
      if (d_valid)
      begin
        cfg[d_slot][ued_pkg::CFG_TOGGLE_BIT] <= ~d_cfg[ued_pkg::CFG_TOGGLE_BIT];
      end
    end
  end

  // Read data for the microcontroller, one cycle after the strobe
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      mcu_rdata <= 8'h00;
      mcu_rvalid <= 1'b0;
    end
    else
    begin
      mcu_rvalid <= mcu_rd;
      mcu_rdata <= mcu_rd ? next_mcu_rdata : 8'h00;
    end
  end

  // Buffer manager data read, one cycle after the strobe
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      bm_mem_rdata <= 8'h00;
    end
    else
    begin
      bm_mem_rdata <= bm_mem_rd ? next_bm_mem_rdata : 8'h00;
    end
  end

  // Lookup answer held until the next request
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      bm_ans_valid <= 1'b0;
      bm_ans <= '{resp: ued_pkg::UED_RESP_IGNORE, use_y: 1'b0, toggle: 1'b0,
                  start_addr: 11'h000, count: 7'h00, size: 7'h00};
    end
    else
    begin
      bm_ans_valid <= bm_req;
      if (bm_req)
      begin
        bm_ans <= next_ans;
      end
    end
  end

  // Completion interrupt pulse, gated per endpoint
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      transaction_irq <= 1'b0;
    end
    else
    begin
      transaction_irq <= d_valid && d_cfg[ued_pkg::CFG_IRQ_ENABLE_BIT];
    end
  end

endmodule : ued_block

`default_nettype wire

// *** hdl/ued_pkg.sv ***
// Constants and types for the endpoint descriptor block of a USB function.
// Assumes a byte-wide microcontroller data bus and a buffer manager on the same clock.
`default_nettype none

package ued_pkg;

  // Memory map of the descriptor RAM, byte addresses on the data bus
  localparam logic [15:0] RAM_BASE = 16'hFD80;
  localparam logic [15:0] RAM_LAST = 16'hFF7F;
  localparam logic [15:0] BUF_SPACE_LAST = 16'hFEEF;
  localparam int unsigned BUF_SPACE_BYTES = 368;
  localparam logic [15:0] OUT_EP0_BUF = 16'hFEF0;
  localparam logic [15:0] IN_EP0_BUF = 16'hFEF8;
  localparam logic [15:0] SETUP_BLOCK = 16'hFF00;
  localparam logic [15:0] OUT_DESC_BASE = 16'hFF08;
  localparam logic [15:0] OUT_RSVD_FIRST = 16'hFF20;
  localparam logic [15:0] OUT_RSVD_LAST = 16'hFF47;
  localparam logic [15:0] IN_DESC_BASE = 16'hFF48;
  localparam logic [15:0] IN_RSVD_FIRST = 16'hFF60;
  localparam logic [15:0] IN_RSVD_LAST = 16'hFF7F;
  localparam logic [15:0] BUF_WINDOW_BASE = 16'hF800;
  localparam int unsigned RAM_BYTES = 512;

  // Descriptor slots: out endpoints 1-3, then in endpoints 1-3
  localparam int unsigned SLOT_COUNT = 6;
  localparam logic [2:0] IN_SLOT_OFFSET = 3'h3;

  // Entry offsets inside one eight-byte descriptor
  localparam logic [2:0] OFS_CONFIGURATION = 3'h0;
  localparam logic [2:0] OFS_X_BASE = 3'h1;
  localparam logic [2:0] OFS_X_COUNT = 3'h2;
  localparam logic [2:0] OFS_SPARE_A = 3'h3;
  localparam logic [2:0] OFS_SPARE_B = 3'h4;
  localparam logic [2:0] OFS_Y_BASE = 3'h5;
  localparam logic [2:0] OFS_Y_COUNT = 3'h6;
  localparam logic [2:0] OFS_BUFFER_SIZE = 3'h7;

  // Configuration byte fields
  localparam int unsigned CFG_IRQ_ENABLE_BIT = 2;
  localparam int unsigned CFG_STALL_BIT = 3;
  localparam int unsigned CFG_DOUBLE_BUF_BIT = 4;
  localparam int unsigned CFG_TOGGLE_BIT = 5;
  localparam int unsigned CFG_ISO_BIT = 6;
  localparam int unsigned CFG_UBM_USE_BIT = 7;
  localparam logic [7:0] CFG_WRITE_MASK = 8'hFC;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] SIZE_WRITE_MASK = 8'h7F;

  // Byte count fields
  localparam int unsigned COUNT_FULL_BIT = 7;
  localparam logic [7:0] COUNT_FULL_MASK = 8'h80;
  localparam logic [6:0] COUNT_MAX = 7'h40;
  localparam logic [2:0] BASE_PAD = 3'h0;

  // Answer to a buffer manager lookup, one-hot
  typedef enum logic [3:0] {
    UED_RESP_IGNORE = 4'h1,
    UED_RESP_NAK = 4'h2,
    UED_RESP_STALL = 4'h4,
    UED_RESP_READY = 4'h8
  } ued_resp_t;

  typedef struct packed {
    logic dir_in;
    logic [1:0] ep;
  } ued_ep_sel_t;

  typedef struct packed {
    ued_resp_t resp;
    logic use_y;
    logic toggle;
    logic [10:0] start_addr;
    logic [6:0] count;
    logic [6:0] size;
  } ued_bm_ans_t;

endpackage : ued_pkg

`default_nettype wire

// *** test/tb_top.sv ***
// Self-checking bench: byte model of the descriptor RAM against the block.
// Assumes ued_bm_model plays the buffer manager; the bench plays firmware.
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [15:0] mcu_addr = 16'h0000;
  logic mcu_wr = 1'b0;
  logic mcu_rd = 1'b0;
  logic [7:0] mcu_wdata = 8'h00;
  logic [7:0] mcu_rdata, bm_mem_rdata, bm_mem_wdata, c;
  logic mcu_rvalid, bm_ans_valid, transaction_irq, bm_req, bm_done, bm_mem_wr, bm_mem_rd;
  ued_pkg::ued_ep_sel_t bm_sel, bm_done_sel;
  logic [6:0] bm_done_count;
  logic [10:0] bm_mem_addr;
  ued_pkg::ued_bm_ans_t bm_ans;
  logic [7:0] m [int];
  int failures = 0;
  int checks_done = 0;
  int seed = 95;
  // Probe addresses on the boundaries of the two holes and of the map below the descriptors
  logic [15:0] probe_addr [10] = '{16'hFF20, 16'hFF47, 16'hFF60, 16'hFF7F, 16'hFD7F, 16'hFD80, 16'hFEEF, 16'hFEF0,
    16'hFEF8, 16'hFF00};
  logic [7:0] look_cfg [6] = '{8'h00, 8'h80, 8'h88, 8'h90, 8'hA0, 8'hB0};
  logic [7:0] done_cfg [5] = '{8'h84, 8'hA4, 8'hB4, 8'h80, 8'h04};

  always #5 clock = ~clock;
  ued_block dut (.*);
  ued_bm_model u_bm (.*);

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic chk_ans(input ued_pkg::ued_bm_ans_t got, input ued_pkg::ued_bm_ans_t exp);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_ans

  task automatic conclude;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude

  // Descriptor slot i: out 1-3, then in 1-3
  function automatic int da(input int i);
    return i < 3 ? 'hFF08 + 8 * i : 'hFF48 + 8 * (i - 3);
  endfunction : da

  function automatic ued_pkg::ued_ep_sel_t sl(input int i);
    return {i >= 3, 2'(i % 3 + 1)};
  endfunction : sl

  // Writes the block keeps, and the bits it keeps of them
  task automatic wr(input int a, input logic [7:0] v);
    @(posedge clock);
    mcu_wr <= 1'b1;
    mcu_addr <= 16'(a);
    mcu_wdata <= v;
    @(posedge clock);
    mcu_wr <= 1'b0;
    mcu_wdata <= ~v;
    if (a >= 16'hFD80 && a < 16'hFF60 && !(a >= 16'hFF20 && a < 16'hFF48)
      && !(a >= 16'hFF08 && (a[2:0] == 3'h3 || a[2:0] == 3'h4)))
      m[a] = a < 16'hFF08 ? v : a[2:0] == 3'h0 ? v & 8'hFC : a[2:0] == 3'h7 ? v & 8'h7F : v;
  endtask : wr

  task automatic rd(input int a);
    @(posedge clock);
    mcu_rd <= 1'b1;
    mcu_addr <= 16'(a);
    @(posedge clock);
    mcu_rd <= 1'b0;
    #1;
    chk_byte(mcu_rdata, m.exists(a) ? m[a] : 8'h00);
  endtask : rd

  task automatic bmem(input logic w, input logic [10:0] a, input logic [7:0] v);
    u_bm.mem(w, a, v);
    #1;
    if (w)
      m[{5'h1F, a}] = v;
    else
      chk_byte(bm_mem_rdata, m[{5'h1F, a}]);
  endtask : bmem

  // Lookup against the model; ignored answers compare the code only
  task automatic look(input ued_pkg::ued_ep_sel_t s);
    ued_pkg::ued_bm_ans_t e;
    int b;
    logic y;
    b = 'hFF00 + (s.dir_in ? 'h40 : 0) + 8 * s.ep;
    e = '0;
    e.resp = ued_pkg::UED_RESP_IGNORE;
    if (s.ep != 0 && m[b][7])
    begin
      y = m[b][4] & m[b][5];
      e.use_y = y;
      e.toggle = m[b][5];
      e.start_addr = {m[b + (y ? 5 : 1)], 3'h0};
      e.count = m[b + (y ? 6 : 2)][6:0];
      e.size = m[b + 7][6:0];
      e.resp = m[b][3] ? ued_pkg::UED_RESP_STALL : m[b + (y ? 6 : 2)][7] ? ued_pkg::UED_RESP_NAK
        : ued_pkg::UED_RESP_READY;
    end
    u_bm.lookup(s);
    #1;
    chk_byte({7'h0, bm_ans_valid}, 8'h01);
    if (e.resp == ued_pkg::UED_RESP_IGNORE)
      chk_byte({4'h0, bm_ans.resp}, 8'h01);
    else
      chk_ans(bm_ans, e);
  endtask : look

  // Completion: flip toggle, mark the buffer chosen by the old state
  task automatic fin(input int i, input logic [6:0] n);
    int k;
    c = m[da(i)];
    k = da(i) + (c[4] & c[5] ? 6 : 2);
    u_bm.done(sl(i), n);
    #1;
    chk_byte({7'h0, transaction_irq}, {7'h0, c[7] & c[2]});
    if (c[7])
    begin
      m[k] = i >= 3 ? m[k] | 8'h80 : {1'b1, n};
      m[da(i)] = c ^ 8'h20;
    end
  endtask : fin

  // Main sequence
  initial
  begin
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      m[da(i)] = 8'h00;
      rd(da(i));
      look(sl(i));
    end
    $display("reset test done");
    for (int i = 0; i < 6; i++)
      for (int o = 0; o < 8; o++)
        wr(da(i) + o, 8'($random(seed) & 8'hBF));
    for (int i = 0; i < 6; i++)
      for (int o = 0; o < 8; o++)
        rd(da(i) + o);
    foreach (probe_addr[j])
    begin
      wr(probe_addr[j], 8'($random(seed)));
      rd(probe_addr[j]);
    end
    bmem(1'b0, 11'h580, 8'h00);
    bmem(1'b1, 11'h6EF, 8'h5A);
    rd(16'hFEEF);
    $display("map test done");
    look(3'h4);
    for (int i = 0; i < 6; i++)
      foreach (look_cfg[j])
      begin
        wr(da(i), look_cfg[j]);
        wr(da(i) + 2, 8'($random(seed) & 8'hBF) | 8'(($random(seed) & 1) << 7));
        wr(da(i) + 6, 8'($random(seed) & 8'hBF) | 8'(($random(seed) & 1) << 7));
        look(sl(i));
      end
    $display("lookup test done");
    for (int i = 0; i < 6; i++)
      foreach (done_cfg[j])
      begin
        wr(da(i), done_cfg[j]);
        fin(i, 7'($unsigned($random(seed)) % 65));
        for (int o = 0; o < 8; o++)
          rd(da(i) + o);
      end
    u_bm.done(3'h0, 7'h01);
    #1;
    chk_byte({7'h0, transaction_irq}, 8'h00);
    $display("completion test done");
    // Second reset mid-run: config bytes clear, RAM bytes keep their contents
    @(posedge clock);
    rstn <= 1'b0;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      m[da(i)] = 8'h00;
      rd(da(i));
      rd(da(i) + 1);
      look(sl(i));
    end
    $display("reset again test done");
    conclude();
  end

  // Watchdog well beyond the roughly 1200 cycles the tests need
  initial
  begin
    #400000;
    failures++;
    conclude();
  end
endmodule : tb_top

bind ued_block ued_block_chk u_chk (.*);
`default_nettype wire

// *** test/ued_block_chk.sv ***
// Checker for the descriptor block: bus answers, lookups, completion flag.
// Assumes it is bound onto ued_block and sees only its ports.
`timescale 1ns/100ps
`default_nettype none

module ued_block_chk (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [15:0] mcu_addr,
  input wire logic mcu_wr,
  input wire logic mcu_rd,
  input wire logic [7:0] mcu_wdata,
  input wire logic [7:0] mcu_rdata,
  input wire logic mcu_rvalid,
  input wire logic bm_req,
  input wire ued_pkg::ued_ep_sel_t bm_sel,
  input wire logic bm_ans_valid,
  input wire ued_pkg::ued_bm_ans_t bm_ans,
  input wire logic bm_done,
  input wire ued_pkg::ued_ep_sel_t bm_done_sel,
  input wire logic [6:0] bm_done_count,
  input wire logic bm_mem_wr,
  input wire logic bm_mem_rd,
  input wire logic [10:0] bm_mem_addr,
  input wire logic [7:0] bm_mem_wdata,
  input wire logic [7:0] bm_mem_rdata,
  input wire logic transaction_irq
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  // Read data only in the answer cycle
  a_read_answer: assert property (mcu_rd |=> mcu_rvalid)
    else $error("read got no answer");
  a_read_quiet: assert property (!mcu_rd |=> !mcu_rvalid && mcu_rdata == 8'h00)
    else $error("read data outside answer");

  // Lookup answer timing and shape
  a_lookup_answer: assert property (bm_req |=> bm_ans_valid && $onehot(bm_ans.resp))
    else $error("lookup answer missing");
  a_answer_holds: assert property (!bm_req |=> $stable(bm_ans))
    else $error("answer moved without lookup");
  a_ep0_ignored: assert property (bm_req && bm_sel.ep == 2'h0 |=> bm_ans.resp == ued_pkg::UED_RESP_IGNORE)
    else $error("endpoint zero not ignored");
  a_base_padded: assert property (bm_ans_valid && bm_ans.resp != ued_pkg::UED_RESP_IGNORE
    |-> bm_ans.start_addr[2:0] == 3'h0)
    else $error("start address not padded");
  a_y_needs_toggle: assert property (bm_ans_valid && bm_ans.use_y |-> bm_ans.toggle)
    else $error("Y buffer with toggle clear");

  // Completion flag has a cause
  a_irq_cause: assert property (transaction_irq |-> $past(bm_done) && $past(bm_done_sel.ep) != 2'h0)
    else $error("flag without completion");
  a_irq_ep0_none: assert property (bm_done && bm_done_sel.ep == 2'h0 |=> !transaction_irq)
    else $error("flag for endpoint zero");
endmodule : ued_block_chk
`default_nettype wire

// *** test/ued_bm_model.sv ***
// Buffer manager stand-in: lookup, completion and buffer data strobes.
// Assumes one caller process; strobes go out just after a rising edge.
`timescale 1ns/100ps
`default_nettype none

module ued_bm_model (
  input wire logic clock,
  output logic bm_req,
  output ued_pkg::ued_ep_sel_t bm_sel,
  output logic bm_done,
  output ued_pkg::ued_ep_sel_t bm_done_sel,
  output logic [6:0] bm_done_count,
  output logic bm_mem_wr,
  output logic bm_mem_rd,
  output logic [10:0] bm_mem_addr,
  output logic [7:0] bm_mem_wdata
);
  // Quiet strobes from time zero
  initial
  begin
    {bm_req, bm_done, bm_mem_wr, bm_mem_rd} = 4'h0;
    {bm_sel, bm_done_sel, bm_done_count} = 13'h0;
    {bm_mem_addr, bm_mem_wdata} = 19'h0;
  end

  // Released selects show the inverse, not the last value
  task automatic lookup(input ued_pkg::ued_ep_sel_t s);
    @(posedge clock);
    bm_req <= 1'b1;
    bm_sel <= s;
    @(posedge clock);
    bm_req <= 1'b0;
    bm_sel <= ~s;
  endtask : lookup

  task automatic done(input ued_pkg::ued_ep_sel_t s, input logic [6:0] n);
    @(posedge clock);
    bm_done <= 1'b1;
    bm_done_sel <= s;
    bm_done_count <= n;
    @(posedge clock);
    bm_done <= 1'b0;
    bm_done_sel <= ~s;
    bm_done_count <= ~n;
  endtask : done

  task automatic mem(input logic w, input logic [10:0] a, input logic [7:0] v);
    @(posedge clock);
    bm_mem_wr <= w;
    bm_mem_rd <= !w;
    bm_mem_addr <= a;
    bm_mem_wdata <= v;
    @(posedge clock);
    {bm_mem_wr, bm_mem_rd} <= 2'h0;
    bm_mem_addr <= ~a;
  endtask : mem
endmodule : ued_bm_model
`default_nettype wire
